// ### src/pkt_stream_client.sv
/*
  Client end of the packet stream. Sends frames handed in by the user port
  and passes received words out only while receive valid is high.
  Assumes the MAC end applies zero ready latency.
*/
`timescale 1ns/1ps
module pkt_stream_client
  import pkt_stream_pkg::*;
  (
  pkt_stream_if.client                link,
  input  wire logic [WORD_BITS-1:0]   send_word,
  input  wire logic                   send_valid,
  input  wire logic                   send_last,
  input  wire logic [UNUSED_BITS-1:0] send_unused,
  output logic                        send_ready,
  output logic [WORD_BITS-1:0]        recv_word,
  output logic                        recv_valid,
  output logic                        recv_first,
  output logic                        recv_last,
  output logic [UNUSED_BITS-1:0]      recv_unused
  );
  logic holding;
  logic mid_frame;

  // Staging register feeds the link; user may load it when empty or draining
  assign send_ready = !holding || link.tx_ready; // RULE9

  always_ff @(posedge link.clk or negedge link.rst_n) begin
    if (!link.rst_n) begin
      holding              <= 1'b0;
      mid_frame            <= 1'b0;
      link.tx_word         <= '0;
      link.tx_word_valid   <= 1'b0;
      link.tx_frame_first  <= 1'b0;
      link.tx_frame_last   <= 1'b0;
      link.tx_unused_bytes <= UNUSED_RESET;
    end else if (send_ready) begin
      // Stall keeps word and qualifiers stable otherwise
      holding              <= send_valid; // RULE10
      link.tx_word_valid   <= send_valid; // RULE1
      if (send_valid) begin
        link.tx_word         <= send_word;
        link.tx_frame_first  <= !mid_frame; // RULE2
        link.tx_frame_last   <= send_last; // RULE3
        link.tx_unused_bytes <= send_last ? send_unused : UNUSED_NONE; // RULE4
        mid_frame            <= !send_last;
      end
    end
  end

  // Receive side: qualifiers pass only with valid
  always_ff @(posedge link.clk or negedge link.rst_n) begin
    if (!link.rst_n) begin
      recv_word   <= '0;
      recv_valid  <= 1'b0;
      recv_first  <= 1'b0;
      recv_last   <= 1'b0;
      recv_unused <= UNUSED_RESET;
    end else begin
      recv_valid <= link.rx_word_valid; // RULE7
      if (link.rx_word_valid) begin
        recv_word   <= link.rx_word;
        recv_first  <= link.rx_frame_first;
        recv_last   <= link.rx_frame_last;
        recv_unused <= link.rx_unused_bytes;
      end
    end
  end
endmodule

// ### src/pkt_stream_if.sv
/*
  Interface joining the MAC-side end and the client end of the packet
  stream. Assumes one clock and an active low asynchronous reset shared
  by both ends.
*/
`timescale 1ns/1ps
interface pkt_stream_if
  import pkt_stream_pkg::*;
  (input wire logic clk,
   input wire logic rst_n);
  // Transmit path, client to MAC
  logic [WORD_BITS-1:0]   tx_word;
  logic                   tx_word_valid;
  logic                   tx_frame_first;
  logic                   tx_frame_last;
  logic [UNUSED_BITS-1:0] tx_unused_bytes;
  logic                   tx_ready;
  // Receive path, MAC to client
  logic [WORD_BITS-1:0]   rx_word;
  logic                   rx_word_valid;
  logic                   rx_frame_first;
  logic                   rx_frame_last;
  logic [UNUSED_BITS-1:0] rx_unused_bytes;

  modport mac (
    input  clk, rst_n, tx_word, tx_word_valid, tx_frame_first, tx_frame_last, tx_unused_bytes,
    output tx_ready, rx_word, rx_word_valid, rx_frame_first, rx_frame_last, rx_unused_bytes
  );
  modport client (
    input  clk, rst_n, tx_ready, rx_word, rx_word_valid, rx_frame_first, rx_frame_last, rx_unused_bytes,
    output tx_word, tx_word_valid, tx_frame_first, tx_frame_last, tx_unused_bytes
  );
endinterface

// ### src/pkt_stream_mac.sv
/*
  MAC-side end of the client packet stream. Transmit words taken from the
  client go through a two-entry buffer to the MAC user port; receive words
  from the MAC user port go through a second two-entry buffer to the client.
  A sticky framing flag reports faults seen on either input.
  Assumes the client end keeps its own framing duties.
*/
`timescale 1ns/1ps
// Summary of operation
// RULE1 - Client keeps tx valid high through frame
// RULE2 - Client marks first word of frame
// RULE3 - Client marks last word of frame
// RULE4 - Last word carries unused low byte count
// RULE5 - Core marks first delivered receive word
// RULE6 - Receive valid only with new word
// RULE7 - Client ignores receive side when invalid
// RULE8 - Core marks last word with unused count
// RULE9 - Transmit accepted same cycle ready high
// RULE10 - Client holds transmit word while not ready
module pkt_stream_mac
  import pkt_stream_pkg::*;
  (
  pkt_stream_if.mac                  link,
  output logic [WORD_BITS-1:0]       txo_word,
  output logic                       txo_valid,
  output logic                       txo_first,
  output logic                       txo_last,
  output logic [UNUSED_BITS-1:0]     txo_unused,
  input  wire logic                  txo_ready,
  input  wire logic [WORD_BITS-1:0]  rxi_word,
  input  wire logic                  rxi_valid,
  input  wire logic                  rxi_first,
  input  wire logic                  rxi_last,
  input  wire logic [UNUSED_BITS-1:0] rxi_unused,
  output logic                       rxi_ready,
  output logic                       frame_error
  );
  localparam int EW = WORD_BITS + 2 + UNUSED_BITS;

  // Local names for the shared clock and reset of the link
  wire           clk_w = link.clk;
  wire           rst_w = link.rst_n;

  logic [EW-1:0] tx_mem [BUF_DEPTH];
  logic [EW-1:0] rx_mem [BUF_DEPTH];
  logic          tx_wp;
  logic          tx_rp;
  logic [1:0]    tx_cnt;
  logic          rx_wp;
  logic          rx_rp;
  logic [1:0]    rx_cnt;
  logic          tx_push;
  logic          tx_pop;
  logic          rx_push;
  logic          rx_pop;
  logic          in_frame;
  logic          rx_in_frame;
  logic          rxi_open;

  // Transmit accept: ready is a pure function of buffer room, so it never
  // waits on valid and a word is taken in the cycle ready is seen high
  assign link.tx_ready = (tx_cnt != 2'(BUF_DEPTH)); // RULE9
  assign tx_push       = link.tx_word_valid && link.tx_ready; // RULE9

  // Buffer head drives the user port; valid means not empty
  assign txo_valid     = (tx_cnt != 2'h0);
  assign tx_pop        = txo_valid && txo_ready;
  assign txo_word      = tx_mem[tx_rp][EW-1 -: WORD_BITS];
  assign txo_first     = tx_mem[tx_rp][UNUSED_BITS+1];
  assign txo_last      = tx_mem[tx_rp][UNUSED_BITS];
  assign txo_unused    = tx_mem[tx_rp][UNUSED_BITS-1:0];

  // Transmit buffer storage
  always_ff @(posedge clk_w) begin
    if (tx_push) begin
      tx_mem[tx_wp] <= {link.tx_word, link.tx_frame_first, link.tx_frame_last,
                        link.tx_frame_last ? link.tx_unused_bytes : UNUSED_NONE}; // RULE4
    end
  end

  // Transmit write pointer steps on every accepted word
  always_ff @(posedge clk_w or negedge rst_w) begin
    if (!rst_w) begin
      tx_wp <= 1'b0;
    end else if (tx_push) begin
      tx_wp <= ~tx_wp;
    end
  end

  // Transmit read pointer steps on every word the sink takes
  always_ff @(posedge clk_w or negedge rst_w) begin
    if (!rst_w) begin
      tx_rp <= 1'b0;
    end else if (tx_pop) begin
      tx_rp <= ~tx_rp;
    end
  end

  // Transmit fill count; a push and a pop in one cycle leave it unchanged
  always_ff @(posedge clk_w or negedge rst_w) begin
    if (!rst_w) begin
      tx_cnt <= 2'h0;
    end else begin
      tx_cnt <= tx_cnt + 2'(tx_push) - 2'(tx_pop);
    end
  end

  // Transmit frame tracker: open after a first word that is not also last
  always_ff @(posedge clk_w or negedge rst_w) begin
    if (!rst_w) begin
      in_frame <= 1'b0;
    end else if (tx_push && link.tx_frame_first && !link.tx_frame_last) begin
      in_frame <= 1'b1;
    end else if (tx_push && link.tx_frame_last) begin
      in_frame <= 1'b0; // RULE3
    end
  end

  // Receive input tracker, apart from the client-side framing, so that a
  // wrong first marker from the MAC core is caught before the buffer
  always_ff @(posedge clk_w or negedge rst_w) begin
    if (!rst_w) begin
      rxi_open <= 1'b0;
    end else if (rx_push) begin
      rxi_open <= !rxi_last;
    end
  end

  // Framing monitor: sticky on a dropped valid or a stray marker; only
  // reset clears it, so a one-cycle fault stays visible
  always_ff @(posedge clk_w or negedge rst_w) begin
    if (!rst_w) begin
      frame_error <= 1'b0;
    end else if (in_frame && !link.tx_word_valid) begin
      frame_error <= 1'b1; // RULE1
    end else if (tx_push && (link.tx_frame_first == in_frame)) begin
      frame_error <= 1'b1; // RULE2
    end else if (rx_push && (rxi_first == rxi_open)) begin
      frame_error <= 1'b1;
    end
  end

  // Receive buffer: MAC side fills, client side drains every valid word
  assign rxi_ready = (rx_cnt != 2'(BUF_DEPTH));
  assign rx_push   = rxi_valid && rxi_ready;
  assign rx_pop    = (rx_cnt != 2'h0);

  // Receive buffer storage
  always_ff @(posedge clk_w) begin
    if (rx_push) begin
      rx_mem[rx_wp] <= {rxi_word, rxi_first, rxi_last, rxi_last ? rxi_unused : UNUSED_NONE};
    end
  end

  // Receive write pointer steps on every word from the MAC core
  always_ff @(posedge clk_w or negedge rst_w) begin
    if (!rst_w) begin
      rx_wp <= 1'b0;
    end else if (rx_push) begin
      rx_wp <= ~rx_wp;
    end
  end

  // Receive read pointer steps on every word sent to the client
  always_ff @(posedge clk_w or negedge rst_w) begin
    if (!rst_w) begin
      rx_rp <= 1'b0;
    end else if (rx_pop) begin
      rx_rp <= ~rx_rp;
    end
  end

  // Receive fill count; the drain every cycle keeps it below full
  always_ff @(posedge clk_w or negedge rst_w) begin
    if (!rst_w) begin
      rx_cnt <= 2'h0;
    end else begin
      rx_cnt <= rx_cnt + 2'(rx_push) - 2'(rx_pop);
    end
  end

  // Registered receive outputs; word holds its value while valid is low
  always_ff @(posedge clk_w or negedge rst_w) begin
    if (!rst_w) begin
      link.rx_word         <= '0;
      link.rx_word_valid   <= 1'b0;
      link.rx_frame_first  <= 1'b0;
      link.rx_frame_last   <= 1'b0;
      link.rx_unused_bytes <= UNUSED_RESET;
    end else begin
      link.rx_word_valid <= rx_pop; // RULE6
      if (rx_pop) begin
        link.rx_word         <= rx_mem[rx_rp][EW-1 -: WORD_BITS];
        link.rx_frame_first  <= !rx_in_frame; // RULE5
        link.rx_frame_last   <= rx_mem[rx_rp][UNUSED_BITS]; // RULE8
        link.rx_unused_bytes <= rx_mem[rx_rp][UNUSED_BITS-1:0]; // RULE8
      end
    end
  end

  // Receive frame tracker; the word after a last word opens a new frame
  always_ff @(posedge clk_w or negedge rst_w) begin
    if (!rst_w) begin
      rx_in_frame <= 1'b0;
    end else if (rx_pop) begin
      rx_in_frame <= !rx_mem[rx_rp][UNUSED_BITS];
    end
  end
endmodule

// ### src/pkt_stream_pkg.sv
/*
  Shared constants for the client packet stream: word width, byte count,
  width of the unused byte count, buffer depth and reset values.
  Assumes both ends and the interface import it.
*/
package pkt_stream_pkg;
  localparam int         WORD_BITS      = 256;
  localparam int         WORD_BYTES     = WORD_BITS / 8;
  localparam int         UNUSED_BITS    = 5;
  localparam int         BUF_DEPTH      = 2;
  localparam logic [4:0] UNUSED_RESET   = 5'h00;
  localparam logic [4:0] UNUSED_NONE    = 5'h00;
  localparam int         READY_LATENCY  = 0;
endpackage

// ### tb/ethernet_client_packet_stream_tb_top.sv
/* Bench joining both packet stream ends over one interface.
   Assumes the receive path is never stalled by the client end. */
`timescale 1ns/1ps
module ethernet_client_packet_stream_tb_top
  import pkt_stream_pkg::*;
  ;
  logic                   clk, rst_n, send_valid, send_last, send_ready, txo_valid, txo_ready;
  logic                   rxi_valid, rxi_first, rxi_last, rxi_ready, frame_error, recv_valid;
  logic [WORD_BITS-1:0]   send_word, txo_word, rxi_word, recv_word;
  logic [UNUSED_BITS-1:0] send_unused, txo_unused, rxi_unused, recv_unused;
  logic                   txo_first, txo_last, recv_first, recv_last;
  logic [262:0]           txq[$], rxq[$];
  int                     num_errors = 0, samples_checked = 0;
  pkt_stream_if pkt_stream_if_inst (.clk(clk), .rst_n(rst_n));
  pkt_stream_mac pkt_stream_mac_inst (.link(pkt_stream_if_inst.mac), .txo_word(txo_word), .txo_valid(txo_valid),
    .txo_first(txo_first), .txo_last(txo_last), .txo_unused(txo_unused), .txo_ready(txo_ready),
    .rxi_word(rxi_word), .rxi_valid(rxi_valid), .rxi_first(rxi_first), .rxi_last(rxi_last),
    .rxi_unused(rxi_unused), .rxi_ready(rxi_ready), .frame_error(frame_error));
  pkt_stream_client pkt_stream_client_inst (.link(pkt_stream_if_inst.client), .send_word(send_word),
    .send_valid(send_valid), .send_last(send_last), .send_unused(send_unused), .send_ready(send_ready),
    .recv_word(recv_word), .recv_valid(recv_valid), .recv_first(recv_first), .recv_last(recv_last),
    .recv_unused(recv_unused));
  pkt_stream_sva pkt_stream_sva_inst (.clk(clk), .rst_n(rst_n), .tx_word(pkt_stream_if_inst.tx_word),
    .tx_word_valid(pkt_stream_if_inst.tx_word_valid), .tx_frame_first(pkt_stream_if_inst.tx_frame_first),
    .tx_frame_last(pkt_stream_if_inst.tx_frame_last), .tx_unused_bytes(pkt_stream_if_inst.tx_unused_bytes),
    .tx_ready(pkt_stream_if_inst.tx_ready), .rx_word_valid(pkt_stream_if_inst.rx_word_valid),
    .rx_frame_first(pkt_stream_if_inst.rx_frame_first), .rx_frame_last(pkt_stream_if_inst.rx_frame_last),
    .rx_unused_bytes(pkt_stream_if_inst.rx_unused_bytes));
  // Clock
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  // Collect words leaving each user side
  always @(posedge clk) begin
    if (txo_valid === 1'b1 && txo_ready === 1'b1) txq.push_back({txo_first, txo_last, txo_unused, txo_word});
    if (recv_valid === 1'b1) rxq.push_back({recv_first, recv_last, recv_unused, recv_word});
  end
  function automatic logic [WORD_BITS-1:0] w(input int i);
    return {(WORD_BITS/32){32'hA5C30000 + i}};
  endfunction
  task automatic chk(input logic [262:0] got, input logic [262:0] exp);
    samples_checked++;
    if (got !== exp) begin
      num_errors++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // Frame sent while the MAC sink stalls long enough to fill the buffer
  task automatic tx_frame(input int n, input logic [4:0] un);
    txq.delete();
    txo_ready <= 1'b0;
    fork
      begin
        for (int i = 0; i < n; i++) begin
          send_word <= w(i);
          send_valid <= 1'b1;
          send_last <= (i == n - 1);
          send_unused <= (i == n - 1) ? un : UNUSED_NONE;
          do @(posedge clk); while (send_ready !== 1'b1);
        end
        // Drop valid at the edge that took the last word, not after the stall
        send_valid <= 1'b0;
      end
      begin
        repeat (8) @(posedge clk);
        txo_ready <= 1'b1;
      end
    join
    repeat (n + 8) @(posedge clk);
    chk(txq.size(), n);
    for (int i = 0; i < n && i < txq.size(); i++)
      chk(txq[i], {i == 0, i == n - 1, (i == n - 1) ? un : UNUSED_NONE, w(i)});
  endtask
  // Frame received with idle gaps between words
  task automatic rx_frame(input int n, input logic [4:0] un);
    rxq.delete();
    for (int i = 0; i < n; i++) begin
      rxi_word <= w(i + 64);
      rxi_valid <= 1'b1;
      rxi_first <= (i == 0);
      rxi_last <= (i == n - 1);
      rxi_unused <= (i == n - 1) ? un : UNUSED_NONE;
      do @(posedge clk); while (rxi_ready !== 1'b1);
      rxi_valid <= 1'b0;
      @(posedge clk);
    end
    repeat (8) @(posedge clk);
    chk(rxq.size(), n);
    for (int i = 0; i < n && i < rxq.size(); i++)
      chk(rxq[i], {i == 0, i == n - 1, (i == n - 1) ? un : UNUSED_NONE, w(i + 64)});
  endtask
  task automatic wrap_up();
    $display("errors=%0d checks=%0d", num_errors, samples_checked);
    if (num_errors == 0 && samples_checked > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  // Watchdog
  initial begin
    repeat (3000) @(posedge clk);
    num_errors++;
    wrap_up();
  end
  // Main sequence
  initial begin
    {rst_n, send_valid, send_last, txo_ready, rxi_valid, rxi_first, rxi_last} = '0;
    {send_word, rxi_word, send_unused, rxi_unused} = '0;
    repeat (20) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    tx_frame(5, 5'h02);
    tx_frame(1, 5'h1F);
    rx_frame(3, 5'h1D);
    rx_frame(1, 5'h00);
    chk(frame_error, 1'b0);
    wrap_up();
  end
endmodule

// ### tb/pkt_stream_sva.sv
/* Assertions on the link between the two packet stream ends.
   Assumes one clock, active low reset, placed beside the interface. */
`timescale 1ns/1ps
module pkt_stream_sva
  import pkt_stream_pkg::*;
  (
  input wire logic                   clk,
  input wire logic                   rst_n,
  input wire logic [WORD_BITS-1:0]   tx_word,
  input wire logic                   tx_word_valid,
  input wire logic                   tx_frame_first,
  input wire logic                   tx_frame_last,
  input wire logic [UNUSED_BITS-1:0] tx_unused_bytes,
  input wire logic                   tx_ready,
  input wire logic                   rx_word_valid,
  input wire logic                   rx_frame_first,
  input wire logic                   rx_frame_last,
  input wire logic [UNUSED_BITS-1:0] rx_unused_bytes
  );
  logic tx_open;
  logic rx_open;
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  // Transmit frame in progress
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) tx_open <= 1'b0;
    else if (tx_word_valid && tx_ready) tx_open <= !tx_frame_last;
  end
  // Receive frame in progress
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) rx_open <= 1'b0;
    else if (rx_word_valid) rx_open <= !rx_frame_last;
  end
  a_tx_valid_held: assert property (tx_open |-> tx_word_valid)
    else $error("tx valid dropped in frame");
  a_tx_first_mark: assert property (tx_word_valid && !tx_open |-> tx_frame_first)
    else $error("tx first marker missing");
  a_tx_first_mid: assert property (tx_word_valid && tx_open |-> !tx_frame_first)
    else $error("tx first marker inside frame");
  a_tx_unused_zero: assert property (tx_word_valid && !tx_frame_last |-> tx_unused_bytes == UNUSED_NONE)
    else $error("tx unused count off last word");
  a_tx_stall_hold: assert property (tx_word_valid && !tx_ready |=> tx_word_valid && $stable(tx_word))
    else $error("tx word changed while stalled");
  a_rx_first_mark: assert property (rx_word_valid && !rx_open |-> rx_frame_first)
    else $error("rx first marker missing");
  a_rx_first_mid: assert property (rx_word_valid && rx_open |-> !rx_frame_first)
    else $error("rx first marker inside frame");
  a_rx_unused_zero: assert property (rx_word_valid && !rx_frame_last |-> rx_unused_bytes == UNUSED_NONE)
    else $error("rx unused count off last word");
  c_tx_stall: cover property (tx_word_valid && !tx_ready);
  c_tx_single: cover property (tx_word_valid && tx_frame_first && tx_frame_last);
  c_rx_last: cover property (rx_word_valid && rx_frame_last);
endmodule
